// *** inc/opc_pkg.sv ***
// package for the oscillator and pll control register block
// assumes an apb slave on clk_sys with 32-bit data

package opc_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_CFG = 6'h04;
	localparam logic [5:0] ADDR_INT = 6'h08;
	localparam logic [5:0] ADDR_APB2RST = 6'h0c;
	localparam logic [5:0] ADDR_APB1RST = 6'h10;
	localparam logic [5:0] ADDR_AHBCLK = 6'h14;
	localparam logic [5:0] ADDR_APB2CLK = 6'h18;
	localparam logic [5:0] ADDR_APB1CLK = 6'h1c;
	localparam logic [5:0] ADDR_BDCTRL = 6'h20;
	localparam logic [5:0] ADDR_CSTS = 6'h24;
	localparam int NUM_REGS = 10;

	// ------------------------------------------------------------
	// clock control field positions
	// ------------------------------------------------------------
	localparam int BIT_INT_ON = 0;
	localparam int BIT_INT_STABLE = 1;
	localparam int TRIM_LO = 3;
	localparam int CAL_LO = 8;
	localparam int BIT_EXT_ON = 16;
	localparam int BIT_EXT_STABLE = 17;
	localparam int BIT_BYPASS = 18;
	localparam int BIT_MON_ON = 19;
	localparam int BIT_PLL_ON = 24;
	localparam int BIT_PLL_LOCKED = 25;
	// writable bits of clock control
	localparam logic [31:0] CTRL_WMASK = 32'h010f_00f9;

	// reset values
	localparam logic [4:0] TRIM_RST = 5'h10;
	localparam logic [7:0] CAL_DEFAULT = 8'h80;

	// interrupt register: failure flag position (own layout)
	localparam int BIT_FAIL_FLAG = 7;
	localparam int BIT_FAIL_CLR = 23;

	// system clock selection codes (configuration bits 1:0 and 3:2)
	typedef enum logic [1:0]
	{
		OPC_SRC_INT = 2'h0,
		OPC_SRC_EXT = 2'h1,
		OPC_SRC_PLL = 2'h2
	} opc_src_e;
	localparam int SEL_LO = 0;
	localparam int STS_LO = 2;
	localparam int BIT_PLL_SRC = 16;

	// stability indications from the analogue side
	typedef struct packed
	{
		logic intStable;
		logic extStable;
		logic pllLocked;
		logic extFail;
	} opc_ana_s;

	// power mode events
	typedef struct packed
	{
		logic softReset;
		logic wakeStandby;
		logic wakeStop;
		logic enterLowPower;
	} opc_pwr_s;

endpackage : opc_pkg

// *** logic/opc_ctrl.sv ***
// oscillator, external clock and pll control register block
// assumes apb master on clk_sys; analogue status inputs are asynchronous
// and pass through two-stage synchronisers here

// Behaviour
// - internal oscillator enable forced on at reset, wake-ups and external clock failure
// - internal enable cannot be cleared while it feeds the system clock
// - bit 1 reads internal oscillator stable, read only
// - five-bit writable trim in bits 7:3
// - factory calibration loaded into read-only bits 15:8 at start-up
// - external enable cleared on entry to standby or stop
// - external enable cannot be cleared while it feeds the system clock
// - external ready set by hardware when stable, cleared by software
// - bypass bit chooses driven clock (1) or resonator (0)
// - bit 19 enables the clock failure monitor
// - pll enable cleared on entry to standby or stop or on monitored failure while fed from external, else software
// - pll enable cannot be cleared while pll is or becomes system clock
// - bit 25 reads pll locked, read only
// - clock control resets to low byte 0x83, upper half zero
// - byte, half-word and word writes complete with no wait cycles
// - ten word registers decoded from 0x00 to 0x24
// - monitored external failure stops external oscillator, and the pll when fed from external, selects internal
// - failure raises monitor interrupt and nmi until software clears the flag
module opc_ctrl #(
	parameter logic [7:0] FACTORY_CAL = opc_pkg::CAL_DEFAULT // arbitrary
)(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire opc_pkg::opc_ana_s anaIn,
	input wire opc_pkg::opc_pwr_s pwrEvt,
	output logic intOscOn,
	output logic [4:0] intOscTrim,
	output logic extOscOn,
	output logic extOscBypass,
	output logic clockMonitorOn,
	output logic multiplierLoopOn,
	output logic [1:0] sysClkSel,
	output logic monitorIrq,
	output logic nmiReq
);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// strobes are byte lanes; zero wait states so pready is tied high
	wire logic access = psel && penable;
	wire logic wrEn = access && pwrite;
	wire logic [5:0] offs = paddr[5:0];
	wire logic inRange = (paddr[31:6] == 26'h0) && (offs[1:0] == 2'h0)
		&& (offs <= opc_pkg::ADDR_CSTS);
	wire logic [31:0] laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
		{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire logic wrCtrl = wrEn && inRange && offs == opc_pkg::ADDR_CTRL;
	wire logic wrCfg = wrEn && inRange && offs == opc_pkg::ADDR_CFG;
	wire logic wrInt = wrEn && inRange && offs == opc_pkg::ADDR_INT;
	assign pready = 1'b1;
	assign pslverr = access && !inRange;

	// ------------------------------------------------------------
	// synchronisers for analogue status
	// ------------------------------------------------------------
	logic [3:0] anaMeta_q;
	logic [3:0] anaSync_q;
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			anaMeta_q <= 4'h0;
			anaSync_q <= 4'h0;
		end
		else
		begin
			anaMeta_q <= anaIn;
			anaSync_q <= anaMeta_q;
		end
	end
	wire logic intStable = anaSync_q[3];
	wire logic extStableNow = anaSync_q[2];
	wire logic pllLocked = anaSync_q[1];
	wire logic extFailSync = anaSync_q[0];

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic intOn_q;
	logic [4:0] trim_q;
	logic [7:0] cal_q;
	logic calLoaded_q;
	logic extOn_q;
	logic extRdy_q;
	logic extStablePrev_q;
	logic bypass_q;
	logic monOn_q;
	logic pllOn_q;
	logic failFlag_q;
	logic [31:0] cfg_q;
	wire logic [31:0] genWord [opc_pkg::NUM_REGS];

	// which sources are feeding the system clock (status field; pll also when only requested)
	wire logic [1:0] selSts = cfg_q[opc_pkg::STS_LO +: 2];
	wire logic [1:0] selReq = cfg_q[opc_pkg::SEL_LO +: 2];
	wire logic pllFromExt = cfg_q[opc_pkg::BIT_PLL_SRC];
	wire logic pllUsed = selSts == opc_pkg::OPC_SRC_PLL
		|| selReq == opc_pkg::OPC_SRC_PLL;
	wire logic extUsed = selSts == opc_pkg::OPC_SRC_EXT
		|| (selSts == opc_pkg::OPC_SRC_PLL && pllFromExt);
	wire logic intUsed = selSts == opc_pkg::OPC_SRC_INT
		|| (selSts == opc_pkg::OPC_SRC_PLL && !pllFromExt);

	// failure only counts when monitored and external drives the system
	wire logic clkFail = monOn_q && extUsed && extFailSync;
	wire logic lowPower = pwrEvt.enterLowPower;
	wire logic wakeUp = pwrEvt.softReset || pwrEvt.wakeStandby
		|| pwrEvt.wakeStop;

	// masked write data for the clock control register
	wire logic [31:0] ctrlW = pwdata & laneMask & opc_pkg::CTRL_WMASK;
	wire logic ctrlLane0 = wrCtrl && pstrb[0];
	wire logic ctrlLane2 = wrCtrl && pstrb[2];
	wire logic ctrlLane3 = wrCtrl && pstrb[3];
	wire logic extRise = extStableNow && !extStablePrev_q;
	wire logic extRdyClr = ctrlLane2 && pwdata[opc_pkg::BIT_EXT_STABLE];

	// internal oscillator enable and trim
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			intOn_q <= 1'b1;
			trim_q <= opc_pkg::TRIM_RST;
		end
		else
		begin
			if (wakeUp || clkFail)
				intOn_q <= 1'b1;
			else if (ctrlLane0)
				intOn_q <= ctrlW[opc_pkg::BIT_INT_ON] || intUsed;
			if (ctrlLane0)
				trim_q <= ctrlW[opc_pkg::TRIM_LO +: 5];
		end
	end

	// calibration is taken once after reset release
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cal_q <= 8'h00;
			calLoaded_q <= 1'b0;
		end
		else if (!calLoaded_q)
		begin
			cal_q <= FACTORY_CAL;
			calLoaded_q <= 1'b1;
		end
	end

	// external oscillator enable, bypass, monitor, ready flag
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			extOn_q <= 1'b0;
			bypass_q <= 1'b0;
			monOn_q <= 1'b0;
			extRdy_q <= 1'b0;
			extStablePrev_q <= 1'b0;
		end
		else
		begin
			extStablePrev_q <= extStableNow;
			if (lowPower || clkFail)
				extOn_q <= 1'b0;
			else if (ctrlLane2)
				extOn_q <= ctrlW[opc_pkg::BIT_EXT_ON] || extUsed;
			if (ctrlLane2)
			begin
				bypass_q <= ctrlW[opc_pkg::BIT_BYPASS];
				monOn_q <= ctrlW[opc_pkg::BIT_MON_ON];
			end
			// a new stable edge wins over a software clear
			if (extRise && extOn_q)
				extRdy_q <= 1'b1;
			else if (extRdyClr || !extOn_q)
				extRdy_q <= 1'b0;
		end
	end

	// pll enable
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			pllOn_q <= 1'b0;
		else if (lowPower || (clkFail && pllFromExt))
			pllOn_q <= 1'b0;
		else if (ctrlLane3)
			pllOn_q <= ctrlW[opc_pkg::BIT_PLL_ON] || pllUsed;
	end

	// ------------------------------------------------------------
	// configuration: selection and switch status
	// ------------------------------------------------------------
	// status follows the request only once the target is ready
	logic [1:0] stsNext;
	always_comb
	begin
		stsNext = selSts;
		case (selReq)
			opc_pkg::OPC_SRC_INT: if (intStable) stsNext = selReq;
			opc_pkg::OPC_SRC_EXT: if (extRdy_q) stsNext = selReq;
			opc_pkg::OPC_SRC_PLL: if (pllLocked) stsNext = selReq;
			default: stsNext = selSts;
		endcase
	end
	wire logic [31:0] cfgW = (pwdata & laneMask)
		| (cfg_q & ~laneMask);
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_q <= 32'h0;
		else if (clkFail || lowPower || wakeUp)
		begin
			cfg_q[opc_pkg::SEL_LO +: 2] <= opc_pkg::OPC_SRC_INT;
			cfg_q[opc_pkg::STS_LO +: 2] <= opc_pkg::OPC_SRC_INT;
		end
		else
		begin
			if (wrCfg)
			begin
				cfg_q[31:4] <= cfgW[31:4];
				cfg_q[opc_pkg::SEL_LO +: 2] <= cfgW[opc_pkg::SEL_LO +: 2];
			end
			cfg_q[opc_pkg::STS_LO +: 2] <= stsNext;
		end
	end

	// ------------------------------------------------------------
	// failure flag
	// ------------------------------------------------------------
	wire logic failClr = wrInt && pstrb[2] && pwdata[opc_pkg::BIT_FAIL_CLR];
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			failFlag_q <= 1'b0;
		else if (clkFail)
			failFlag_q <= 1'b1;
		else if (failClr)
			failFlag_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// plain storage registers (offsets 0x0c..0x24)
	// ------------------------------------------------------------
	// index 0..2 unused here; each word keeps its own flop so that
	// every element of the read array has exactly one driver
	genvar gi;
	generate
		for (gi = 0; gi < opc_pkg::NUM_REGS; gi++)
		begin : genStore
			if (gi < 3)
			begin : genUnused
				assign genWord[gi] = 32'h0;
			end
			else
			begin : genUsed
				logic [31:0] word_q;
				wire logic hit = wrEn && inRange && offs == 6'(gi * 4);
				always_ff @(posedge clk_sys or posedge sys_rst)
				begin
					if (sys_rst)
						word_q <= 32'h0;
					else if (hit)
						word_q <= (pwdata & laneMask) | (word_q & ~laneMask);
				end
				assign genWord[gi] = word_q;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [31:0] ctrlRd;
	always_comb
	begin
		ctrlRd = 32'h0;
		ctrlRd[opc_pkg::BIT_INT_ON] = intOn_q;
		ctrlRd[opc_pkg::BIT_INT_STABLE] = intStable && intOn_q;
		ctrlRd[opc_pkg::TRIM_LO +: 5] = trim_q;
		ctrlRd[opc_pkg::CAL_LO +: 8] = cal_q;
		ctrlRd[opc_pkg::BIT_EXT_ON] = extOn_q;
		ctrlRd[opc_pkg::BIT_EXT_STABLE] = extRdy_q;
		ctrlRd[opc_pkg::BIT_BYPASS] = bypass_q;
		ctrlRd[opc_pkg::BIT_MON_ON] = monOn_q;
		ctrlRd[opc_pkg::BIT_PLL_ON] = pllOn_q;
		ctrlRd[opc_pkg::BIT_PLL_LOCKED] = pllLocked && pllOn_q;
	end
	wire logic [31:0] intRd = 32'(failFlag_q) << opc_pkg::BIT_FAIL_FLAG;
	wire logic [31:0] rdMux = !inRange ? 32'h0
		: offs == opc_pkg::ADDR_CTRL ? ctrlRd
		: offs == opc_pkg::ADDR_CFG ? cfg_q
		: offs == opc_pkg::ADDR_INT ? intRd
		: genWord[offs[5:2]];
	// prdata registered at setup so it is valid through the access phase
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rdMux;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign intOscOn = intOn_q;
	assign intOscTrim = trim_q;
	assign extOscOn = extOn_q;
	assign extOscBypass = bypass_q;
	assign clockMonitorOn = monOn_q;
	assign multiplierLoopOn = pllOn_q;
	assign sysClkSel = selSts;
	assign monitorIrq = failFlag_q;
	assign nmiReq = failFlag_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_int_forced: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wakeUp || clkFail) |=> intOn_q)
		else $error("internal oscillator not forced on");
	chk_int_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(intUsed && intOn_q && !wrCfg) |=> intOn_q)
		else $error("internal enable cleared while in use");
	chk_ext_lowpwr: assert property (@(posedge clk_sys) disable iff (sys_rst)
		lowPower |=> !extOn_q && !pllOn_q)
		else $error("sources not stopped in low power");
	chk_ext_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(extUsed && extOn_q && !lowPower && !clkFail) |=> extOn_q)
		else $error("external enable cleared while in use");
	chk_ext_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(extRise && extOn_q) |=> extRdy_q)
		else $error("external ready not set");
	chk_pll_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pllUsed && pllOn_q && !lowPower && !clkFail) |=> pllOn_q)
		else $error("pll enable cleared while selected");
	chk_fail_switch: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkFail |=> sysClkSel == opc_pkg::OPC_SRC_INT && !extOn_q
		&& failFlag_q)
		else $error("failure did not switch to internal");
	chk_fail_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(failFlag_q && !failClr) |=> nmiReq)
		else $error("failure flag dropped without clear");
	chk_reserved_zero: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		(ctrlRd & ~32'h030f_fffb) == 32'h0)
		else $error("reserved control bits not zero");
	chk_ready_sync: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(anaIn.pllLocked) && pllOn_q ##1 pllOn_q
		|-> !ctrlRd[opc_pkg::BIT_PLL_LOCKED])
		else $error("pll ready not synchronised");
	chk_no_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
		access |-> pready)
		else $error("wait state inserted");

endmodule : opc_ctrl

// *** verification/tb.sv ***
// self-checking bench for the oscillator and pll control block
// assumes opc_pkg compiled first; bench is the apb master and drives
// the analogue status and power event inputs itself
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] ACTL = {26'h0, opc_pkg::ADDR_CTRL};
	localparam logic [31:0] ACFG = {26'h0, opc_pkg::ADDR_CFG};
	localparam logic [31:0] AINT = {26'h0, opc_pkg::ADDR_INT};
	logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rdv;
	logic [3:0] pstrb;
	opc_pkg::opc_ana_s anaIn;
	opc_pkg::opc_pwr_s pwrEvt;
	logic intOscOn, extOscOn, extOscBypass, clockMonitorOn;
	logic multiplierLoopOn, monitorIrq, nmiReq, lastErr;
	logic [4:0] intOscTrim;
	logic [1:0] sysClkSel;
	int errTotal, checkCount;

	// calibration differs from the default so a missing load shows
	opc_ctrl #(.FACTORY_CAL(8'h5a)) DUT (.clk_sys, .sys_rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .anaIn, .pwrEvt, .intOscOn, .intOscTrim, .extOscOn,
		.extOscBypass, .clockMonitorOn, .multiplierLoopOn, .sysClkSel,
		.monitorIrq, .nmiReq);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		checkCount++;
		if (g !== e)
		begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [31:0] a, d,
		input logic [3:0] s);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		// only the watchdog ends a wait that never completes
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rdv = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d, 4'hf);
	endtask : wr

	task automatic rd(input string nm, input logic [31:0] a, e);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(nm, e, rdv);
	endtask : rd

	// let the edge updates land before looking at outputs
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	// status inputs pass a synchroniser, so allow a few edges
	task automatic ana(input logic [3:0] v);
		@(posedge clk_sys);
		anaIn <= v;
		tick(6);
	endtask : ana

	task automatic pwr(input logic [3:0] v);
		@(posedge clk_sys);
		pwrEvt <= v;
		@(posedge clk_sys);
		pwrEvt <= 4'h0;
		tick(3);
	endtask : pwr

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// clock, watchdog and tests
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		errTotal++;
		complete_run();
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		anaIn = 4'b1000;
		pwrEvt = 4'h0;
		sys_rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		tick(6);
		rd("ctrl reset", ACTL, 32'h0000_5a83);
		wr(ACTL, 32'hffff_ffff);
		rd("ctrl ones", ACTL, 32'h010d_5afb);
		chk("trim", 32'h1f, 32'(intOscTrim));
		chk("bypass", 32'h1, 32'(extOscBypass));
		chk("monitor", 32'h1, 32'(clockMonitorOn));
		// only lane 0 may change
		apb(1'b1, ACTL, 32'hffff_ff41, 4'h1);
		rd("ctrl byte", ACTL, 32'h010d_5a43);
		tick(1);
		chk("trim byte", 32'h08, 32'(intOscTrim));
		// internal feeds the system clock, so its enable survives
		wr(ACTL, 32'h0);
		rd("ctrl zero", ACTL, 32'h0000_5a03);
		wr(ACTL, 32'h0001_0001);
		ana(4'b1100);
		rd("ext ready", ACTL, 32'h0003_5a03);
		wr(ACFG, 32'h1);
		tick(4);
		chk("sel ext", 32'h1, 32'(sysClkSel));
		wr(ACTL, 32'h0100_0000);
		ana(4'b1110);
		rd("ext kept", ACTL, 32'h0303_5a00);
		// pll fed from external picked as system clock: clear refused
		wr(ACFG, 32'h0001_0002);
		tick(4);
		chk("sel pll", 32'h2, 32'(sysClkSel));
		wr(ACTL, 32'h0001_0000);
		rd("pll kept", ACTL, 32'h0303_5a00);
		chk("pll lock", 32'h1, 32'(rdv[25]));
		// low-power entry drops external and pll
		pwr(4'b0001);
		chk("ext off", 32'h0, 32'(extOscOn));
		chk("pll off", 32'h0, 32'(multiplierLoopOn));
		chk("sel int", 32'h0, 32'(sysClkSel));
		for (int i = 1; i < 4; i++)
		begin
			pwr(4'(1 << i));
			chk("int wake", 32'h1, 32'(intOscOn));
		end
		ana(4'b1000);
		// monitored failure of the external system clock
		wr(ACTL, 32'h0009_0001);
		ana(4'b1100);
		wr(ACFG, 32'h1);
		tick(4);
		chk("sel ext2", 32'h1, 32'(sysClkSel));
		wr(ACTL, 32'h0009_0000);
		tick(1);
		chk("int clr", 32'h0, 32'(intOscOn));
		ana(4'b1101);
		chk("fail ext", 32'h0, 32'(extOscOn));
		chk("fail sel", 32'h0, 32'(sysClkSel));
		chk("fail int", 32'h1, 32'(intOscOn));
		chk("fail irq", 32'h1, 32'(monitorIrq));
		chk("fail nmi", 32'h1, 32'(nmiReq));
		apb(1'b0, AINT, 32'h0, 4'h0);
		chk("fail flag", 32'h1, 32'(rdv[7]));
		ana(4'b1100);
		tick(4);
		chk("irq held", 32'h1, 32'(monitorIrq));
		wr(AINT, 32'h0080_0000);
		tick(2);
		chk("irq clr", 32'h0, 32'(monitorIrq));
		chk("nmi clr", 32'h0, 32'(nmiReq));
		// ready flag needs a fresh stable edge, then software clears it
		wr(ACTL, 32'h0001_0001);
		ana(4'b1000);
		ana(4'b1100);
		rd("ext rdy", ACTL, 32'h0003_5a03);
		wr(ACTL, 32'h0003_0001);
		rd("rdy clr", ACTL, 32'h0001_5a03);
		// plain storage words, then an address beyond the map and a misaligned one
		for (int i = 3; i < 10; i++)
			wr(32'(4 * i), 32'h5ac3_0f00 + 32'(i));
		for (int i = 3; i < 10; i++)
			rd("store", 32'(4 * i), 32'h5ac3_0f00 + 32'(i));
		rd("unmapped", 32'h28, 32'h0);
		chk("slverr", 32'h1, 32'(lastErr));
		wr(32'h26, 32'hffff_ffff);
		chk("slverr2", 32'h1, 32'(lastErr));
		// second reset in mid-run
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		tick(6);
		rd("ctrl rst2", ACTL, 32'h0000_5a83);
		rd("store rst", 32'h0c, 32'h0);
		complete_run();
	end

endmodule : tb
